/* File: rtl/gudc_top.v */
/*
  Gated 32-bit up/down counter with compare, sticky flags and a
  process interrupt record. Assumes count pulses and control bits are
  synchronous to mclk; the input track levels are asynchronous pins.
*/
`timescale 1ns/1ns
`include "gudc_defines.vh"
module gudc_top (
  mclk,
  rst,
  count_up,
  count_down,
  count_mode,
  main_dir,
  gate_interrupt,
  load_value,
  end_value,
  compare_value,
  compare_mode,
  hyst_width,
  gate_open_request,
  gate_close_request,
  compare_output_enabled,
  status_flags_clear,
  irq_enable,
  diag_enable,
  supply_ok,
  track_pins,
  reg_addr,
  reg_rdata,
  count_value,
  software_count_gate,
  compare_level_flag,
  compare_latched_flag,
  overflow_flag,
  underflow_flag,
  process_irq,
  diag_irq
);
  input         mclk;
  input         rst;
  input         count_up;
  input         count_down;
  input  [1:0]  count_mode;
  input  [1:0]  main_dir;
  input         gate_interrupt;
  input  [31:0] load_value;
  input  [31:0] end_value;
  input  [31:0] compare_value;
  input  [2:0]  compare_mode;
  input  [7:0]  hyst_width;
  input         gate_open_request;
  input         gate_close_request;
  input         compare_output_enabled;
  input         status_flags_clear;
  input         irq_enable;
  input         diag_enable;
  input         supply_ok;
  input  [2:0]  track_pins;
  input  [2:0]  reg_addr;
  output [15:0] reg_rdata;
  output [31:0] count_value;
  output        software_count_gate;
  output        compare_level_flag;
  output        compare_latched_flag;
  output        overflow_flag;
  output        underflow_flag;
  output        process_irq;
  output        diag_irq;

  localparam TICK_DIV = `GUDC_TICK_NS / `GUDC_CLK_NS;

  reg [31:0] count_reg;
  reg        gate_reg;
  reg        open_d_reg;
  reg        close_d_reg;
  reg        compare_latched_flag;
  reg        overflow_flag;
  reg        underflow_flag;
  reg        process_irq;
  reg        diag_irq;
  reg        supply_d_reg;
  reg [7:0]  event_reg;
  reg [7:0]  inputs_reg;
  reg [15:0] tick_reg;
  reg [15:0] tick_stamp_reg;
  reg [7:0]  tick_div_reg;
  reg [2:0]  pin_s1_reg;
  reg [2:0]  pin_s2_reg;
  reg [15:0] reg_rdata;
  reg [31:0] count_next;
  reg        gate_next;
  reg        limit_evt;
  reg        ovf_evt;
  reg        unf_evt;
  wire       open_edge;
  wire       close_edge;
  wire       step;
  wire       step_up;
  wire       level_set;

  assign count_value         = count_reg;
  assign software_count_gate = gate_reg;
  // [R25] One qualified pulse at a time
  assign step    = gate_reg && (count_up ^ count_down);
  assign step_up = count_up;

  // [R9] Rising edges of control bits
  assign open_edge  = gate_open_request && !open_d_reg;
  assign close_edge = gate_close_request && !close_d_reg;

  //////////////////////////////////////////////////////////////////////////
  always @* begin
    count_next = count_reg;
    gate_next  = gate_reg;
    limit_evt  = 1'b0;
    ovf_evt    = 1'b0;
    unf_evt    = 1'b0;
    if (step) begin
      if (step_up) begin
        count_next = count_reg + `GUDC_ONE;
      end else begin
        count_next = count_reg - `GUDC_ONE;
      end
      // [R4] [R5] [R6] Full-range wrap beyond a main direction
      if (step_up && count_reg == `GUDC_CNT_MAX) begin
        ovf_evt = 1'b1;
      end
      if (!step_up && count_reg == `GUDC_CNT_MIN) begin
        unf_evt = 1'b1;
      end
      // [R1] [R7] Forward end reached
      if (main_dir == `GUDC_DIR_FWD && step_up &&
          count_reg == end_value - `GUDC_ONE) begin
        count_next = load_value;
        limit_evt  = 1'b1;
        ovf_evt    = 1'b0;
      end
      // [R2] [R8] Backward end reached
      if (main_dir == `GUDC_DIR_BWD && !step_up &&
          count_reg == end_value + `GUDC_ONE) begin
        count_next = load_value;
        limit_evt  = 1'b1;
        unf_evt    = 1'b0;
      end
      // [R1] [R2] Once mode closes gate at end
      if (count_mode == `GUDC_MODE_ONCE &&
          (limit_evt || ovf_evt || unf_evt)) begin
        gate_next = 1'b0;
      end
    end
    // [R10] Internal gate follows software gate
    if (close_edge) begin
      gate_next = 1'b0;
    end
    // [R11] [R3] Only a fresh rising edge reopens
    if (open_edge && !gate_reg) begin
      gate_next = 1'b1;
      // [R12] [R13] Abort reloads, interrupt resumes
      if (!gate_interrupt) begin
        count_next = load_value;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  gudc_compare u_cmp (
    .mclk               (mclk),
    .rst                (rst),
    .count              (count_next),
    .step               (step),
    .step_up            (step_up),
    .compare_value      (compare_value),
    .compare_mode       (compare_mode),
    .main_dir           (main_dir),
    .hyst_width         (hyst_width),
    .enable             (compare_output_enabled),
    .level_set          (level_set),
    .compare_level_flag (compare_level_flag)
  );

  //////////////////////////////////////////////////////////////////////////
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg            <= 32'h00000000;
      gate_reg             <= 1'b0;
      open_d_reg           <= 1'b0;
      close_d_reg          <= 1'b0;
      compare_latched_flag <= 1'b0;
      overflow_flag        <= 1'b0;
      underflow_flag       <= 1'b0;
      process_irq          <= 1'b0;
      diag_irq             <= 1'b0;
      supply_d_reg         <= 1'b0;
      event_reg            <= 8'h00;
      inputs_reg           <= 8'h00;
      tick_reg             <= 16'h0000;
      tick_stamp_reg       <= 16'h0000;
      tick_div_reg         <= 8'h00;
      pin_s1_reg           <= 3'h0;
      pin_s2_reg           <= 3'h0;
    end else begin
      count_reg   <= count_next;
      gate_reg    <= gate_next;
      open_d_reg  <= gate_open_request;
      close_d_reg <= gate_close_request;
      pin_s1_reg  <= track_pins;
      pin_s2_reg  <= pin_s1_reg;
      // Microsecond ticker from a clock divider
      if (tick_div_reg == TICK_DIV[7:0] - 8'h01) begin
        tick_div_reg <= 8'h00;
        tick_reg     <= tick_reg + 16'h0001;
      end else begin
        tick_div_reg <= tick_div_reg + 8'h01;
      end
      // [R17] Latched flag, set wins over clear
      if (level_set) begin
        compare_latched_flag <= 1'b1;
      end else if (status_flags_clear) begin
        compare_latched_flag <= 1'b0;
      end
      // [R24] Sticky overflow and underflow
      if (ovf_evt) begin
        overflow_flag <= 1'b1;
      end else if (status_flags_clear) begin
        overflow_flag <= 1'b0;
      end
      if (unf_evt) begin
        underflow_flag <= 1'b1;
      end else if (status_flags_clear) begin
        underflow_flag <= 1'b0;
      end
      // [R21] [R24] Interrupt record snapshot
      process_irq <= 1'b0;
      if (irq_enable && (ovf_evt || unf_evt || limit_evt || level_set)) begin
        process_irq    <= 1'b1;
        event_reg      <= 8'h00;
        event_reg[`GUDC_EVT_LIMIT] <= ovf_evt | unf_evt | limit_evt;
        event_reg[`GUDC_EVT_CMP]   <= level_set;
        inputs_reg     <= {5'h00, pin_s2_reg};
        tick_stamp_reg <= tick_reg;
      end
      // [R22] Supply loss only with diag already on
      supply_d_reg <= supply_ok;
      diag_irq     <= supply_d_reg && !supply_ok && diag_enable;
    end
  end

  // Record read port, unmapped reads zero
  always @* begin
    case (reg_addr)
      `GUDC_REG_EVENT:  reg_rdata = {8'h00, event_reg};
      `GUDC_REG_INPUTS: reg_rdata = {8'h00, inputs_reg};
      `GUDC_REG_TICK:   reg_rdata = tick_stamp_reg;
      default:          reg_rdata = 16'h0000;
    endcase
  end
endmodule

/* File: rtl/gudc_defines.vh */
/*
  Constants of the gated up/down counter with compare.
  Assumes inclusion by bare name from every design file of the block.
*/
//
// Behaviour
// [R1] Once, forward: pulse up at end-1 reloads load value and closes gate.
// [R2] Once, backward: pulse down at end+1 reloads load value, closes gate.
// [R3] Controller must raise gate edge after auto close; restart at load.
// [R4] Forward direction: count below lower limit; end -2^31+1..2^31-1.
// [R5] Backward direction: count above upper limit; end -2^31..2^31-2.
// [R6] Periodic, no direction: wrap at signed 32-bit limits and continue.
// [R7] Periodic forward: pulse up at end-1 reloads load, gate stays open.
// [R8] Periodic backward: pulse down at end+1 reloads load, gate open.
// [R9] Software gate opens on rising open bit, closes on rising close bit.
// [R10] Internal gate follows the software gate state.
// [R11] Auto-closed gate reopens only on a fresh rising open bit.
// [R12] Abort behaviour: reopening restarts from the load value.
// [R13] Interrupt behaviour: reopening resumes from the held count.
// [R14] Compare level flag changes only while compare output is enabled.
// [R15] At-or-above / at-or-below modes: flag follows relation; none: held.
// [R16] Equal mode sets on reaching value, from main direction if set.
// [R17] Level flag setting also sets latched flag until status clear.
// [R18] Hysteresis width 0..255; 0 or 1 disables; applies to all events.
// [R19] Width change takes effect only at next hysteresis activation.
// [R20] Condition met activates hysteresis; result frozen inside range.
// [R21] Interrupt record: event byte, input byte, 16-bit tick snapshot.
// [R22] Supply-missing diag only if diag enabled when supply was lost.
// [R23] Compare field: 000 none, 001 at/above, 010 at/below, 100 equal.
// [R24] Overflow/underflow flags sticky until status clear; raise irq.
// [R25] 32-bit two's-complement count, one step per pulse while open.
`ifndef GUDC_DEFINES_VH
`define GUDC_DEFINES_VH
`define GUDC_MODE_ONCE     2'h1
`define GUDC_MODE_PERIODIC 2'h2
`define GUDC_DIR_NONE      2'h0
`define GUDC_DIR_FWD       2'h1
`define GUDC_DIR_BWD       2'h2
`define GUDC_CMP_NONE      3'h0
`define GUDC_CMP_GE        3'h1
`define GUDC_CMP_LE        3'h2
`define GUDC_CMP_EQ        3'h4
`define GUDC_CNT_MAX       32'h7fffffff
`define GUDC_CNT_MIN       32'h80000000
`define GUDC_ONE           32'h00000001
`define GUDC_HYST_MIN      8'h02
`define GUDC_REG_EVENT     3'h2
`define GUDC_REG_INPUTS    3'h3
`define GUDC_REG_TICK      3'h4
`define GUDC_EVT_LIMIT     2
`define GUDC_EVT_CMP       3
`define GUDC_TICK_NS       1000
`define GUDC_CLK_NS        4
`endif

/* File: rtl/gudc_compare.v */
/*
  Comparison unit with hysteresis window for the counter.
  Assumes count updates arrive as single-cycle step pulses on mclk.
*/
`timescale 1ns/1ns
`include "gudc_defines.vh"
module gudc_compare (
  mclk,
  rst,
  count,
  step,
  step_up,
  compare_value,
  compare_mode,
  main_dir,
  hyst_width,
  enable,
  level_set,
  compare_level_flag
);
  input         mclk;
  input         rst;
  input  [31:0] count;
  input         step;
  input         step_up;
  input  [31:0] compare_value;
  input  [2:0]  compare_mode;
  input  [1:0]  main_dir;
  input  [7:0]  hyst_width;
  input         enable;
  output        level_set;
  output        compare_level_flag;

  reg        compare_level_flag;
  reg        hyst_active_reg;
  reg [31:0] hyst_lo_reg;
  reg [31:0] hyst_hi_reg;
  reg        cond;
  wire       in_window;
  wire       dir_ok;

  assign dir_ok = (main_dir == `GUDC_DIR_NONE) ||
                  (main_dir == `GUDC_DIR_FWD && step_up) ||
                  (main_dir == `GUDC_DIR_BWD && !step_up);
  assign in_window = ($signed(count) >= $signed(hyst_lo_reg)) &&
                     ($signed(count) <= $signed(hyst_hi_reg));

  // [R15] [R16] [R23] Condition per mode
  always @* begin
    case (compare_mode)
      `GUDC_CMP_GE: cond = $signed(count) >= $signed(compare_value);
      `GUDC_CMP_LE: cond = $signed(count) <= $signed(compare_value);
      `GUDC_CMP_EQ: cond = (count == compare_value) &&
                           (compare_level_flag || dir_ok);
      default:      cond = compare_level_flag;
    endcase
  end

  // Level changes only when unfrozen and enabled
  assign level_set = enable && step && !compare_level_flag && cond &&
                     !(hyst_active_reg && in_window) &&
                     compare_mode != `GUDC_CMP_NONE;

  //////////////////////////////////////////////////////////////////////////
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      compare_level_flag <= 1'b0;
      hyst_active_reg    <= 1'b0;
      hyst_lo_reg        <= 32'h00000000;
      hyst_hi_reg        <= 32'h00000000;
    end else if (step) begin
      // [R20] Frozen while inside window
      if (hyst_active_reg && in_window) begin
        hyst_active_reg <= 1'b1;
      end else begin
        hyst_active_reg <= 1'b0;
        // [R14] Gated by compare output enable
        if (enable && compare_mode != `GUDC_CMP_NONE) begin
          compare_level_flag <= cond;
        end
        // [R18] [R19] Window latched at activation only
        if (cond && !compare_level_flag && hyst_width >= `GUDC_HYST_MIN) begin
          hyst_active_reg <= 1'b1;
          hyst_lo_reg     <= count - {24'h000000, hyst_width};
          hyst_hi_reg     <= count + {24'h000000, hyst_width};
        end
      end
    end
  end
endmodule

/* File: dv/gudc_assertions.sv */
/* Checker of count, gate and flag relations of gudc_top.
   Assumes one clock domain, bound below by port name. */
`timescale 1ns/1ns
module gudc_assertions (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        count_up,
  input wire logic        count_down,
  input wire logic [1:0]  count_mode,
  input wire logic [1:0]  main_dir,
  input wire logic        gate_interrupt,
  input wire logic [31:0] load_value,
  input wire logic [31:0] end_value,
  input wire logic        gate_open_request,
  input wire logic        gate_close_request,
  input wire logic        compare_output_enabled,
  input wire logic        status_flags_clear,
  input wire logic [31:0] count_value,
  input wire logic        software_count_gate,
  input wire logic        compare_level_flag,
  input wire logic        compare_latched_flag,
  input wire logic        overflow_flag,
  input wire logic        underflow_flag,
  input wire logic        irq_enable,
  input wire logic        process_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic up1;
  logic dn1;
  // A close edge in the same cycle still lets the step land; the step terms exclude it anyway
  assign up1 = software_count_gate && count_up && !count_down
    && !gate_close_request;
  assign dn1 = software_count_gate && count_down && !count_up
    && !gate_close_request;
  ////////////////////////////////////////////////////////////
  a_up_step: assert property (
    up1 && count_mode == 2'h2 && main_dir == 2'h0
    |=> count_value == $past(count_value) + 32'h1)
    else $error("up step wrong");
  a_down_step: assert property (
    dn1 && count_mode == 2'h2 && main_dir == 2'h0
    |=> count_value == $past(count_value) - 32'h1)
    else $error("down step wrong");
  a_fwd_reload: assert property (
    up1 && main_dir == 2'h1 && count_value == end_value - 32'h1
    |=> count_value == $past(load_value))
    else $error("forward reload missing");
  a_once_close: assert property (
    up1 && count_mode == 2'h1 && main_dir == 2'h1
    && count_value == end_value - 32'h1 |=> !software_count_gate)
    else $error("gate not closed at end");
  a_bwd_reload: assert property (
    dn1 && main_dir == 2'h2 && count_value == end_value + 32'h1
    |=> count_value == $past(load_value))
    else $error("backward reload missing");
  a_closed_hold: assert property (
    !software_count_gate ##1 !software_count_gate
    |-> $stable(count_value))
    else $error("count moved with gate closed");
  a_abort_load: assert property (
    $rose(gate_open_request) && !software_count_gate && !gate_interrupt
    |=> software_count_gate && count_value == $past(load_value))
    else $error("abort reopen wrong");
  a_resume_count: assert property (
    $rose(gate_open_request) && !software_count_gate && gate_interrupt
    |=> software_count_gate && $stable(count_value))
    else $error("interrupt reopen wrong");
  a_close_edge: assert property (
    $rose(gate_close_request) && !$rose(gate_open_request)
    |=> !software_count_gate)
    else $error("gate did not close");
  a_flag_frozen: assert property (
    !compare_output_enabled |=> $stable(compare_level_flag))
    else $error("level flag moved while disabled");
  a_latch_set: assert property (
    $rose(compare_level_flag) |-> compare_latched_flag)
    else $error("latched flag not set");
  a_latch_hold: assert property (
    compare_latched_flag && !status_flags_clear |=> compare_latched_flag)
    else $error("latched flag lost");
  a_ovfl_hold: assert property (
    overflow_flag && !status_flags_clear |=> overflow_flag)
    else $error("overflow flag lost");
  a_unfl_hold: assert property (
    underflow_flag && !status_flags_clear |=> underflow_flag)
    else $error("underflow flag lost");
  a_irq_ovfl: assert property (
    $past(irq_enable) && $rose(overflow_flag) |-> process_irq)
    else $error("no interrupt on overflow");
  c_end: cover property (up1 && count_value == end_value - 32'h1);
  c_cmp: cover property ($rose(compare_latched_flag));
  c_res: cover property ($rose(gate_open_request) && gate_interrupt);
endmodule

bind gudc_top gudc_assertions u_chk (.mclk, .rst, .count_up, .count_down,
  .count_mode, .main_dir, .gate_interrupt, .load_value, .end_value,
  .gate_open_request, .gate_close_request, .compare_output_enabled,
  .status_flags_clear, .count_value, .software_count_gate,
  .compare_level_flag, .compare_latched_flag, .overflow_flag,
  .underflow_flag, .irq_enable, .process_irq);

/* File: dv/gudc_encoder.sv */
/* Encoder model giving count pulses, in bursts or spaced.
   Assumes pulse() is called just after a rising mclk edge. */
`timescale 1ns/1ns
module gudc_encoder (
  input  wire logic mclk,
  output logic      count_up,
  output logic      count_down
);
  initial begin
    count_up = 1'b0;
    count_down = 1'b0;
  end
  // Nonzero gap leaves one idle cycle after each pulse; every call
  // ends idle so back-to-back calls never glitch a pulse line
  task automatic pulse(input logic up, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      count_up = up;
      count_down = !up;
      @(posedge mclk);
      #1;
      if (gap != 0 || i == n - 1) begin
        count_up = 1'b0;
        count_down = 1'b0;
        @(posedge mclk);
        #1;
      end
    end
  endtask
endmodule

/* File: dv/tb_gated_updown_counter_compare.sv */
/* Testbench of gudc_top with the encoder model on its pulse inputs.
   Assumes the checker binds itself to gudc_top. */
`timescale 1ns/1ns
module tb_gated_updown_counter_compare;
  logic        mclk, rst, count_up, count_down, gate_interrupt;
  logic [1:0]  count_mode, main_dir;
  logic [31:0] load_value, end_value, compare_value, count_value;
  logic [2:0]  compare_mode, reg_addr;
  logic        gate_open_request, gate_close_request, irq_enable;
  logic        compare_output_enabled, status_flags_clear;
  logic        software_count_gate, compare_level_flag;
  logic        compare_latched_flag, overflow_flag;
  logic [15:0] reg_rdata;
  logic [7:0]  hyst_width;
  logic        supply_ok, diag_enable, diag_irq, process_irq;
  logic        underflow_flag;
  int          fails, checks_done;

  gudc_encoder enc (.mclk(mclk), .count_up(count_up),
    .count_down(count_down));
  gudc_top dut (.mclk(mclk), .rst(rst), .count_up(count_up),
    .count_down(count_down), .count_mode(count_mode),
    .main_dir(main_dir), .gate_interrupt(gate_interrupt),
    .load_value(load_value), .end_value(end_value),
    .compare_value(compare_value), .compare_mode(compare_mode),
    .hyst_width(hyst_width), .gate_open_request(gate_open_request),
    .gate_close_request(gate_close_request),
    .compare_output_enabled(compare_output_enabled),
    .status_flags_clear(status_flags_clear), .irq_enable(irq_enable),
    .diag_enable(diag_enable), .supply_ok(supply_ok), .track_pins(3'h0),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .count_value(count_value),
    .software_count_gate(software_count_gate),
    .compare_level_flag(compare_level_flag),
    .compare_latched_flag(compare_latched_flag),
    .overflow_flag(overflow_flag), .underflow_flag(underflow_flag),
    .process_irq(process_irq), .diag_irq(diag_irq));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic gate_pulse(input logic open);
    gate_open_request = open;
    gate_close_request = !open;
    cyc(1);
    gate_open_request = 1'b0;
    gate_close_request = 1'b0;
    cyc(1);
  endtask
  task automatic setup(input logic [1:0] m, d, input logic [31:0] ld, ev);
    gate_pulse(1'b0);
    count_mode = m;
    main_dir = d;
    load_value = ld;
    end_value = ev;
    gate_interrupt = 1'b0;
    gate_pulse(1'b1);
  endtask
  task automatic clear_flags;
    status_flags_clear = 1'b1;
    cyc(1);
    status_flags_clear = 1'b0;
    cyc(1);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic s_regs;
    for (int a = 0; a < 8; a++) begin
      reg_addr = a[2:0];
      cyc(1);
      chk("record", 32'h0, 32'(reg_rdata));
    end
  endtask
  task automatic s_once;
    setup(2'h1, 2'h1, 32'ha, 32'he);
    enc.pulse(1'b1, 3, 0);
    chk("count", 32'hd, count_value);
    enc.pulse(1'b1, 1, 1);
    chk("count", 32'ha, count_value);
    chk("gate", 32'h0, 32'(software_count_gate));
    reg_addr = 3'h2;
    cyc(1);
    chk("event", 32'h4, 32'(reg_rdata));
    enc.pulse(1'b1, 2, 1);
    chk("count", 32'ha, count_value);
    gate_pulse(1'b1);
    chk("gate", 32'h1, 32'(software_count_gate));
    setup(2'h1, 2'h2, 32'hfffffffb, 32'hfffffff8);
    enc.pulse(1'b0, 2, 0);
    chk("count", 32'hfffffff9, count_value);
    enc.pulse(1'b0, 1, 0);
    chk("count", 32'hfffffffb, count_value);
    chk("gate", 32'h0, 32'(software_count_gate));
  endtask
  task automatic s_periodic;
    setup(2'h2, 2'h1, 32'h0, 32'h3);
    enc.pulse(1'b1, 4, 0);
    chk("count", 32'h1, count_value);
    chk("gate", 32'h1, 32'(software_count_gate));
    setup(2'h2, 2'h2, 32'h0, 32'hfffffffd);
    enc.pulse(1'b0, 4, 1);
    chk("count", 32'hffffffff, count_value);
    setup(2'h2, 2'h0, 32'h7fffffff, 32'h0);
    enc.pulse(1'b1, 1, 0);
    chk("count", 32'h80000000, count_value);
    enc.pulse(1'b0, 1, 0);
    chk("count", 32'h7fffffff, count_value);
    chk("overflow", 32'h1, 32'(overflow_flag));
    chk("underflow", 32'h1, 32'(underflow_flag));
    clear_flags();
    chk("overflow", 32'h0, 32'(overflow_flag));
    chk("underflow", 32'h0, 32'(underflow_flag));
  endtask
  task automatic s_diag;
    chk("diag", 32'h0, 32'(diag_irq));
    supply_ok = 1'b1;
    cyc(2);
    supply_ok = 1'b0;
    cyc(1);
    chk("diag", 32'h1, 32'(diag_irq));
    cyc(1);
    chk("diag", 32'h0, 32'(diag_irq));
    supply_ok = 1'b1;
    diag_enable = 1'b0;
    cyc(2);
    supply_ok = 1'b0;
    cyc(1);
    chk("diag", 32'h0, 32'(diag_irq));
  endtask
  // Window of +/-3 around 2 keeps the level set down to -1
  task automatic s_hyst;
    setup(2'h2, 2'h0, 32'h0, 32'h0);
    compare_value = 32'h2;
    compare_mode = 3'h1;
    compare_output_enabled = 1'b1;
    hyst_width = 8'h03;
    enc.pulse(1'b0, 1, 0);
    enc.pulse(1'b1, 3, 0);
    chk("level", 32'h1, 32'(compare_level_flag));
    hyst_width = 8'h01;
    enc.pulse(1'b0, 2, 0);
    chk("level", 32'h1, 32'(compare_level_flag));
    enc.pulse(1'b0, 2, 0);
    chk("level", 32'h0, 32'(compare_level_flag));
    enc.pulse(1'b1, 4, 0);
    enc.pulse(1'b0, 1, 0);
    chk("level", 32'h0, 32'(compare_level_flag));
  endtask
  task automatic s_gate;
    setup(2'h2, 2'h0, 32'h0, 32'h0);
    enc.pulse(1'b1, 3, 0);
    gate_interrupt = 1'b1;
    gate_pulse(1'b0);
    enc.pulse(1'b1, 2, 1);
    gate_pulse(1'b1);
    chk("count", 32'h3, count_value);
    gate_interrupt = 1'b0;
    gate_pulse(1'b0);
    gate_pulse(1'b1);
    chk("count", 32'h0, count_value);
  endtask
  task automatic s_compare;
    compare_value = 32'h5;
    compare_mode = 3'h1;
    compare_output_enabled = 1'b1;
    enc.pulse(1'b1, 5, 0);
    chk("level", 32'h1, 32'(compare_level_flag));
    chk("latched", 32'h1, 32'(compare_latched_flag));
    enc.pulse(1'b0, 1, 0);
    chk("level", 32'h0, 32'(compare_level_flag));
    chk("latched", 32'h1, 32'(compare_latched_flag));
    clear_flags();
    chk("latched", 32'h0, 32'(compare_latched_flag));
    compare_mode = 3'h2;
    enc.pulse(1'b0, 1, 0);
    chk("level", 32'h1, 32'(compare_level_flag));
    compare_mode = 3'h4;
    enc.pulse(1'b1, 1, 0);
    chk("level", 32'h0, 32'(compare_level_flag));
    enc.pulse(1'b1, 1, 0);
    chk("level", 32'h1, 32'(compare_level_flag));
    compare_output_enabled = 1'b0;
    enc.pulse(1'b1, 1, 0);
    chk("level", 32'h1, 32'(compare_level_flag));
  endtask
  task automatic wrap_up;
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up();
  end
  initial begin
    {rst, irq_enable} = 2'h3;
    {gate_open_request, gate_close_request, status_flags_clear} = 3'h0;
    {count_mode, main_dir, gate_interrupt} = 5'h0;
    {load_value, end_value, compare_value} = 96'h0;
    {compare_mode, reg_addr, compare_output_enabled} = 7'h0;
    hyst_width = 8'h00;
    // Supply absent from startup with diagnostics already on
    {supply_ok, diag_enable} = 2'h1;
    cyc(12);
    rst = 1'b0;
    cyc(1);
    s_diag();
    s_regs();
    s_once();
    s_periodic();
    s_gate();
    s_compare();
    s_hyst();
    wrap_up();
  end
endmodule
